// File: acs_adc_sequencer.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acs_adc_sequencer
  import acs_pkg::*;
(
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // axi4-lite write address
  input wire logic [15:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [15:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // conversion clock ticks and low-power modes
  input wire logic E_TICK,
  input wire logic RC_TICK,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  // analog front end
  input wire logic COMP_IN,
  output logic [3:0] MUX_SEL,
  output logic [4:0] SRC_KIND,
  output logic SAMPLE_CLOSE,
  output logic [7:0] DAC_CODE,
  output logic CONV_POWER
);
  // register state
  acs_ctl_s ctl_q; // mode and channel
  acs_opt_s opt_q; // power, clock, exit delay
  logic done_q; // conversions_done_flag
  logic [7:0] res_q [4]; // result_reg_one..four
  acs_state_e state_q; // sequencer state
  logic [1:0] idx_q; // position in sequence

  // bus state
  logic aw_hold_q; // address captured
  logic [15:0] awaddr_q;
  logic w_hold_q; // data captured
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // internal nets
  logic wr_do; // write performed this cycle
  logic wr_hit; // write decodes to a register
  logic wr_ctl; // control/status write
  logic wr_opt; // option write
  logic halted; // stop, wait or power off
  logic conv_tick; // selected conversion clock
  logic eng_run;
  logic eng_done;
  logic [7:0] eng_result;
  logic eng_sample;
  logic [7:0] eng_dac;
  logic [3:0] sel_d; // channel to convert now
  logic [8:0] rd_ar; // read decode of the offered address

  // read decode: {hit, data}
  function automatic logic [8:0] rd_word(input logic [15:0] a);
    logic [8:0] r;
    r = 9'h000;
    unique case (a)
      ACS_OFS_CTL: r = {1'b1, done_q, 1'b0, ctl_q};
      ACS_OFS_RES0: r = {1'b1, res_q[0]};
      ACS_OFS_RES1: r = {1'b1, res_q[1]};
      ACS_OFS_RES2: r = {1'b1, res_q[2]};
      ACS_OFS_RES3: r = {1'b1, res_q[3]};
      ACS_OFS_OPT: r = {1'b1, opt_q[2:1], 1'b0, opt_q[0], 4'h0};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  // channel code to source kind
  function automatic acs_src_e src_of(input logic [3:0] c);
    acs_src_e s;
    s = ACS_SRC_RSVD;
    if (!c[3]) begin
      s = ACS_SRC_EXT;
    end else if (c == ACS_CH_HIGH_REF) begin
      s = ACS_SRC_HIGH;
    end else if (c == ACS_CH_LOW_REF) begin
      s = ACS_SRC_LOW;
    end else if (c == ACS_CH_HALF_REF) begin
      s = ACS_SRC_HALF;
    end
    return s;
  endfunction

  assign wr_do = aw_hold_q && w_hold_q && !BVALID;
  assign wr_hit = rd_word(awaddr_q) >> 8 != 9'h000;
  assign wr_ctl = wr_do && wstrb_q[0] && (awaddr_q == ACS_OFS_CTL);
  assign wr_opt = wr_do && wstrb_q[0] && (awaddr_q == ACS_OFS_OPT);
  assign halted = STOP_MODE || WAIT_MODE || !opt_q.converter_power_up;
  assign conv_tick = opt_q.conv_clock_select ? RC_TICK : E_TICK;
  assign eng_run = (state_q == ACS_RUN);

  // read decode of the offered address, hit flag in bit 8
  always_comb begin
    rd_ar = rd_word(ARADDR);
  end

  // group mode keeps the group bits and steps the low two
  always_comb begin
    sel_d = ctl_q.chan;
    if (ctl_q.group_mode) begin
      sel_d = {ctl_q.chan[3:2], idx_q};
    end
  end

  // write address channel, held until the response is taken
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AWREADY <= 1'b1;
      aw_hold_q <= 1'b0;
      awaddr_q <= 16'h0000;
    end else if (CLK_EN) begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_hold_q <= 1'b1;
        awaddr_q <= AWADDR;
      end else if (wr_do) begin
        aw_hold_q <= 1'b0;
      end else if (BVALID && BREADY) begin
        AWREADY <= 1'b1;
      end
    end
  end

  // write data channel, taken in either order with the address
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WREADY <= 1'b1;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (CLK_EN) begin
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        w_hold_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end else if (wr_do) begin
        w_hold_q <= 1'b0;
      end else if (BVALID && BREADY) begin
        WREADY <= 1'b1;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BVALID <= 1'b0;
      BRESP <= ACS_RESP_OKAY;
    end else if (CLK_EN) begin
      if (wr_do) begin
        BVALID <= 1'b1;
        BRESP <= wr_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // read channel, data registered at the address handshake
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= ACS_RESP_OKAY;
    end else if (CLK_EN) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= {24'h000000, rd_ar[7:0]};
        RRESP <= rd_ar[8] ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // control fields; the flag and bit 6 are not writable
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl_q <= ACS_CTL_RST;
    end else if (CLK_EN && wr_ctl) begin
      ctl_q.scan <= wdata_q[ACS_CTL_SCAN_BIT];
      ctl_q.group_mode <= wdata_q[ACS_CTL_GROUP_BIT];
      ctl_q.chan <= wdata_q[3:0];
    end
  end

  // option fields: power, clock select, stop exit delay
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      opt_q <= ACS_OPT_RST;
    end else if (CLK_EN && wr_opt) begin
      opt_q.converter_power_up <= wdata_q[ACS_OPT_PWR_BIT];
      opt_q.conv_clock_select <= wdata_q[ACS_OPT_CONV_CLOCK_SELECT_BIT];
      opt_q.stop_exit_delay <= wdata_q[ACS_OPT_DLY_BIT];
    end
  end

  // sequencer: idle, armed for one e tick, running, suspended
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ACS_IDLE;
    end else if (CLK_EN) begin
      if (wr_ctl) begin
        state_q <= ACS_ARMED;
      end else begin
        unique case (state_q)
          // nothing runs until software writes control
          ACS_IDLE: state_q <= ACS_IDLE;
          // wait one e clock before the first sample
          ACS_ARMED: begin
            if (E_TICK) begin
              state_q <= halted ? ACS_SUSP : ACS_RUN;
            end
          end
          // converting; one-shot stops after the fourth
          ACS_RUN: begin
            if (halted) begin
              state_q <= ACS_SUSP;
            end else if (eng_done && idx_q == 2'h3 && !ctl_q.scan) begin
              state_q <= ACS_IDLE;
            end
          end
          // suspended; resuming restarts the channel's sample
          ACS_SUSP: begin
            if (!halted) begin
              state_q <= ACS_RUN;
            end
          end
        endcase
      end
    end
  end

  // sequence position, wraps so scan mode cycles registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idx_q <= 2'h0;
    end else if (CLK_EN) begin
      if (wr_ctl) begin
        idx_q <= 2'h0;
      end else if (eng_done && eng_run) begin
        idx_q <= idx_q + 2'h1;
      end
    end
  end

  // result registers, one per sequence position
  for (genvar k = 0; k < 4; k++) begin : g_res
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        res_q[k] <= ACS_RES_RST;
      end else if (CLK_EN && !wr_ctl && eng_done && eng_run &&
                   idx_q == 2'(k)) begin
        res_q[k] <= eng_result;
      end
    end
  end

  // done flag: set at the fourth end period, an abort clears it
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_q <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_ctl) begin
        done_q <= 1'b0;
      end else if (eng_done && eng_run && idx_q == 2'h3) begin
        done_q <= 1'b1;
      end
    end
  end

  // multiplexer select and source decode, registered
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MUX_SEL <= 4'h0;
      SRC_KIND <= ACS_SRC_EXT;
    end else if (CLK_EN) begin
      MUX_SEL <= sel_d;
      SRC_KIND <= src_of(sel_d);
    end
  end

  // converter power follows the option bit
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CONV_POWER <= 1'b0;
    end else if (CLK_EN) begin
      CONV_POWER <= opt_q.converter_power_up;
    end
  end

  // one conversion engine, restarted whenever it stops running
  acs_sar_engine u_eng (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .clk_en(CLK_EN),
    .run(eng_run),
    .tick(conv_tick),
    .comp_in(COMP_IN),
    .sample_on(eng_sample),
    .dac_code(eng_dac),
    .done(eng_done),
    .result(eng_result)
  );

  assign SAMPLE_CLOSE = eng_sample;
  assign DAC_CODE = eng_dac;
endmodule // acs_adc_sequencer
`default_nettype wire

// File: acs_pkg.sv
`default_nettype none
// shared constants and types of the conversion sequencer
package acs_pkg;
  // register byte addresses
  localparam logic [15:0] ACS_OFS_CTL = 16'h1030;
  localparam logic [15:0] ACS_OFS_RES0 = 16'h1034;
  localparam logic [15:0] ACS_OFS_RES1 = 16'h1038;
  localparam logic [15:0] ACS_OFS_RES2 = 16'h103C;
  localparam logic [15:0] ACS_OFS_RES3 = 16'h1040;
  localparam logic [15:0] ACS_OFS_OPT = 16'h1044;
  // control/status field positions
  localparam int ACS_CTL_DONE_BIT = 7;
  localparam int ACS_CTL_SCAN_BIT = 5;
  localparam int ACS_CTL_GROUP_BIT = 4;
  // option field positions
  localparam int ACS_OPT_PWR_BIT = 7;
  localparam int ACS_OPT_CONV_CLOCK_SELECT_BIT = 6;
  localparam int ACS_OPT_DLY_BIT = 4;
  // reset values
  localparam logic [5:0] ACS_CTL_RST = 6'h00;
  localparam logic [7:0] ACS_RES_RST = 8'h00;
  localparam logic [2:0] ACS_OPT_RST = 3'h0;
  // conversion timing in conversion-clock cycles
  localparam int ACS_CONV_CYCLES = 32;
  localparam int ACS_SAMPLE_CYCLES = 12;
  localparam int ACS_SAR_BITS = 8;
  localparam logic [4:0] ACS_CNT_LAST = 5'(ACS_CONV_CYCLES - 1);
  localparam logic [4:0] ACS_CNT_SMP = 5'(ACS_SAMPLE_CYCLES);
  localparam logic [4:0] ACS_CNT_SARL =
    5'(ACS_SAMPLE_CYCLES + ACS_SAR_BITS - 1);
  localparam logic [7:0] ACS_SAR_SEED = 8'h80;
  // internal channel codes
  localparam logic [3:0] ACS_CH_HIGH_REF = 4'hC;
  localparam logic [3:0] ACS_CH_LOW_REF = 4'hD;
  localparam logic [3:0] ACS_CH_HALF_REF = 4'hE;
  // bus responses
  localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;
  // control register contents
  typedef struct packed {
    logic scan;
    logic group_mode;
    logic [3:0] chan;
  } acs_ctl_s;
  // option register contents
  typedef struct packed {
    logic converter_power_up;
    logic conv_clock_select;
    logic stop_exit_delay;
  } acs_opt_s;
  // sequencer states
  typedef enum logic [3:0] {
    ACS_IDLE = 4'b0001,
    ACS_ARMED = 4'b0010,
    ACS_RUN = 4'b0100,
    ACS_SUSP = 4'b1000
  } acs_state_e;
  // source selected by the multiplexer
  typedef enum logic [4:0] {
    ACS_SRC_EXT = 5'b00001,
    ACS_SRC_HIGH = 5'b00010,
    ACS_SRC_LOW = 5'b00100,
    ACS_SRC_HALF = 5'b01000,
    ACS_SRC_RSVD = 5'b10000
  } acs_src_e;
endpackage
`default_nettype wire

// File: acs_sar_engine.sv
`timescale 1ns/10ps
`default_nettype none
// one 32-cycle conversion: sample, approximate, end period
module acs_sar_engine
  import acs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic comp_in,
  // analog side
  output logic sample_on,
  output logic [7:0] dac_code,
  // result
  output logic done,
  output logic [7:0] result
);
  logic [4:0] cnt_q; // cycle within conversion
  logic [4:0] cnt_d;
  logic [2:0] bit_idx; // bit under trial
  logic in_sar; // approximation cycle

  // counter restarts whenever run drops, so a resume re-samples
  always_comb begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = 5'h00;
    end else if (tick) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  assign in_sar = (cnt_q >= ACS_CNT_SMP) && (cnt_q <= ACS_CNT_SARL);
  assign bit_idx = 3'(ACS_CNT_SARL - cnt_q);

  // conversion cycle counter, wraps after the end period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  // sampling switch closed for the first twelve cycles only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_on <= 1'b0;
    end else if (clk_en) begin
      sample_on <= run && (cnt_d < ACS_CNT_SMP);
    end
  end

  // successive approximation, one bit per cycle, msb first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code <= 8'h00;
    end else if (clk_en && run && tick) begin
      if (cnt_q == ACS_CNT_SMP - 5'h01) begin
        dac_code <= ACS_SAR_SEED;
      end else if (in_sar) begin
        dac_code[bit_idx] <= comp_in;
        if (bit_idx != 3'h0) begin
          dac_code[bit_idx - 3'h1] <= 1'b1;
        end
      end
    end
  end

  // end period hands the finished code over
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      result <= ACS_RES_RST;
    end else if (clk_en) begin
      done <= run && tick && (cnt_q == ACS_CNT_LAST);
      if (run && tick && (cnt_q == ACS_CNT_LAST)) begin
        result <= dac_code;
      end
    end
  end
endmodule // acs_sar_engine
`default_nettype wire

// File: acs_adc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// port checks of the conversion sequencer
module acs_adc_monitor
  import acs_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // register bus
  input wire logic [15:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [15:0] ARADDR,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  // conversion side
  input wire logic E_TICK,
  input wire logic RC_TICK,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic [3:0] MUX_SEL,
  input wire logic [4:0] SRC_KIND,
  input wire logic SAMPLE_CLOSE,
  input wire logic CONV_POWER
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic [4:0] e_cnt_q; // e ticks with the switch closed
  logic [4:0] r_cnt_q; // r-c ticks with the switch closed
  logic [15:0] ar_q; // address of the read under way
  logic wrote_q; // control register written since reset
  logic [4:0] kind_exp; // source kind for the selected code
  logic halt; // stop or wait asked for
  assign halt = STOP_MODE | WAIT_MODE;
  // count ticks of the sampling window
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      e_cnt_q <= 5'h00;
      r_cnt_q <= 5'h00;
    end else if (!SAMPLE_CLOSE) begin
      e_cnt_q <= 5'h00;
      r_cnt_q <= 5'h00;
    end else begin
      e_cnt_q <= e_cnt_q + 5'(E_TICK);
      r_cnt_q <= r_cnt_q + 5'(RC_TICK);
    end
  end
  // remember read address and first control write
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ar_q <= 16'h0000;
      wrote_q <= 1'b0;
    end else begin
      if (ARVALID && ARREADY)
        ar_q <= ARADDR;
      if (AWVALID && AWREADY && AWADDR == ACS_OFS_CTL)
        wrote_q <= 1'b1;
    end
  end
  // decode of the channel code
  always_comb begin
    case (MUX_SEL)
      ACS_CH_HIGH_REF: kind_exp = ACS_SRC_HIGH;
      ACS_CH_LOW_REF: kind_exp = ACS_SRC_LOW;
      ACS_CH_HALF_REF: kind_exp = ACS_SRC_HALF;
      default: kind_exp = MUX_SEL[3] ? ACS_SRC_RSVD : ACS_SRC_EXT;
    endcase
  end
  sample_len_a: assert property (
    SAMPLE_CLOSE |-> e_cnt_q < ACS_CNT_SMP || r_cnt_q < ACS_CNT_SMP)
    else $error("sampling window too long");
  power_gate_a: assert property (
    !CONV_POWER && !$past(CONV_POWER) && !$past(CONV_POWER, 2)
    |-> !SAMPLE_CLOSE) else $error("sampling while unpowered");
  halt_gate_a: assert property (
    halt && $past(halt) && $past(halt, 2) |-> !SAMPLE_CLOSE)
    else $error("sampling during stop or wait");
  idle_reset_a: assert property (
    !wrote_q |-> !SAMPLE_CLOSE) else $error("conversion before write");
  src_map_a: assert property (
    $stable(MUX_SEL) |-> SRC_KIND == kind_exp)
    else $error("source kind wrong");
  rdata_fmt_a: assert property (
    RVALID |-> RDATA[31:8] == 24'h000000 &&
    !(ar_q == ACS_OFS_CTL && RDATA[6])) else $error("read format wrong");
  aw_busy_a: assert property (
    AWVALID && AWREADY |=> !AWREADY) else $error("second write taken");
  b_answer_a: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("no write response");
  b_done_a: assert property (
    BVALID && BREADY |=> !BVALID) else $error("response repeated");
  r_answer_a: assert property (
    ARVALID && ARREADY |-> ##[1:2] RVALID) else $error("no read data");
  r_done_a: assert property (
    RVALID && RREADY |=> !RVALID) else $error("read data repeated");
endmodule // acs_adc_monitor
`default_nettype wire

// File: acs_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
// analog sources and comparator seen by the converter
module acs_analog_model
  import acs_pkg::*;
(
  // levels of the eight external inputs
  input wire logic [63:0] ext_lv,
  // converter side
  input wire logic [3:0] mux_sel,
  input wire logic [7:0] dac_code,
  output logic comp_in
);
  logic [7:0] lv; // level of the selected source
  // sixteen-way source choice
  always_comb begin
    case (mux_sel)
      ACS_CH_HIGH_REF: lv = 8'hFF;
      ACS_CH_LOW_REF: lv = 8'h00;
      ACS_CH_HALF_REF: lv = 8'h80;
      default: lv = mux_sel[3] ? 8'h3C : ext_lv[8 * mux_sel[2:0] +: 8];
    endcase
  end
  // keep the trial bit while the input is at or above it
  assign comp_in = (lv >= dac_code);
endmodule // acs_analog_model
`default_nettype wire

// File: acs_adc_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end \
end
// self-checking bench of the conversion sequencer
module acs_adc_sequencer_tb_top import acs_pkg::*;;
  logic REF_CLK = 0, ARST_N = 0, CLK_EN = 1;
  logic [15:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA;
  logic [3:0] WSTRB = 4'hF, MUX_SEL;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic E_TICK = 0, RC_TICK = 0, STOP_MODE = 0, WAIT_MODE = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, COMP_IN;
  logic SAMPLE_CLOSE, CONV_POWER;
  logic [1:0] BRESP, RRESP, rsp;
  logic [4:0] SRC_KIND;
  logic [7:0] DAC_CODE;
  logic [7:0][7:0] ext = '0; // external input levels
  logic [31:0] rdat; // data of the last read
  logic [3:0] ch; // channel code of a scan test
  int error_cnt = 0, cmp_count = 0, cyc = 0, rc_n = 0;
  acs_adc_sequencer uut (.REF_CLK, .ARST_N, .CLK_EN, .AWADDR, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .E_TICK, .RC_TICK, .STOP_MODE, .WAIT_MODE, .COMP_IN, .MUX_SEL,
    .SRC_KIND, .SAMPLE_CLOSE, .DAC_CODE, .CONV_POWER);
  acs_analog_model u_ana (.ext_lv(ext), .mux_sel(MUX_SEL),
    .dac_code(DAC_CODE), .comp_in(COMP_IN));
  // 250 mhz clock
  initial begin
    forever #2 REF_CLK = ~REF_CLK;
  end
  // e ticks every second cycle, r-c ticks every third; hang guard
  always @(posedge REF_CLK) begin
    E_TICK <= ~E_TICK;
    rc_n <= (rc_n == 2) ? 0 : rc_n + 1;
    RC_TICK <= (rc_n == 2);
    cyc++;
    if (cyc == 50000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // level expected for a channel code
  function automatic logic [31:0] exp_lv(input logic [3:0] c);
    if (!c[3])
      return {24'h000000, ext[c[2:0]]};
    case (c)
      4'hC: return 32'h000000FF;
      4'hD: return 32'h00000000;
      4'hE: return 32'h00000080;
      default: return 32'h0000003C;
    endcase
  endfunction
  // bus write, address and data offered together
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= {24'h000000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(posedge REF_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    BREADY <= 1'b0;
    rsp = BRESP;
  endtask
  // bus read
  task automatic rd(input logic [15:0] a);
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever begin
      @(posedge REF_CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    RREADY <= 1'b0;
    rsp = RRESP;
    rdat = RDATA;
  endtask
  // poll until the sequence reports complete
  task automatic wdone();
    do rd(ACS_OFS_CTL); while (rdat[7] !== 1'b1);
  endtask
  // compare the four results with the sources converted
  task automatic chkres(input logic [7:0] c);
    for (int k = 0; k < 4; k++) begin
      rd(ACS_OFS_RES0 + 16'(4 * k));
      `CHK("result", exp_lv(c[4] ? {c[3:2], 2'(k)} : c[3:0]), rdat)
    end
  endtask
  // start a sequence, check flag cleared, wait and check results
  task automatic go(input logic [7:0] c);
    wr(ACS_OFS_CTL, c);
    rd(ACS_OFS_CTL);
    `CHK("control", {26'h0, c[5:0]}, rdat)
    wdone();
    chkres(c);
  endtask
  // new random input levels
  task automatic newlv();
    @(posedge REF_CLK);
    for (int i = 0; i < 8; i++)
      ext[i] <= 8'($urandom);
  endtask
  // e ticks from one sample start to the next
  task automatic period();
    int n;
    n = 0;
    do @(posedge REF_CLK); while (SAMPLE_CLOSE);
    do @(posedge REF_CLK); while (!SAMPLE_CLOSE);
    do begin @(posedge REF_CLK); n += int'(E_TICK); end while (SAMPLE_CLOSE);
    do begin @(posedge REF_CLK); n += int'(E_TICK); end while (!SAMPLE_CLOSE);
    `CHK("period", 32, n)
  endtask
  // print counts and verdict
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hC431));
    newlv();
    repeat (8) @(posedge REF_CLK);
    ext[0] <= 8'h00;
    ext[7] <= 8'hFF;
    ARST_N <= 1'b1;
    repeat (60) @(posedge REF_CLK);
    `CHK("idle", 1'b0, SAMPLE_CLOSE)
    rd(ACS_OFS_CTL);
    `CHK("ctl reset", 32'h0, rdat & 32'hC0)
    $display("test reset done");
    wr(ACS_OFS_OPT, 8'h80);
    for (int c = 0; c < 16; c++)
      go(8'(c));
    for (int g = 0; g < 4; g++)
      go({4'h1, 2'(g), 2'($urandom)});
    $display("test one-shot done");
    ch = 4'($urandom % 8);
    go({4'h2, ch});
    period();
    newlv();
    repeat (600) @(posedge REF_CLK);
    chkres({4'h2, ch});
    ch = 4'($urandom);
    go({4'h3, ch});
    newlv();
    repeat (600) @(posedge REF_CLK);
    rd(ACS_OFS_CTL);
    `CHK("flag kept", 1'b1, rdat[7])
    chkres({4'h3, ch});
    $display("test scan done");
    for (int m = 0; m < 2; m++) begin
      wr(ACS_OFS_CTL, 8'h05);
      repeat (40) @(posedge REF_CLK);
      {STOP_MODE, WAIT_MODE} <= m ? 2'b01 : 2'b10;
      repeat (30) @(posedge REF_CLK);
      {STOP_MODE, WAIT_MODE} <= 2'b00;
      wdone();
      chkres(8'h05);
    end
    $display("test suspend done");
    wr(ACS_OFS_OPT, 8'hD0);
    rd(ACS_OFS_OPT);
    `CHK("option", 32'hD0, rdat)
    go(8'hDC);
    wr(ACS_OFS_RES0, 8'h55);
    `CHK("resp", ACS_RESP_OKAY, rsp)
    chkres(8'h1C);
    rd(16'h1050);
    `CHK("unmapped", ACS_RESP_SLVERR, rsp)
    `CHK("unmapped data", 32'h0, rdat)
    wr(ACS_OFS_OPT, 8'h00);
    wr(ACS_OFS_CTL, 8'h01);
    repeat (400) @(posedge REF_CLK);
    rd(ACS_OFS_CTL);
    `CHK("unpowered", 1'b0, rdat[7])
    // clock enable low must freeze a running sequence
    wr(ACS_OFS_OPT, 8'h80);
    wr(ACS_OFS_CTL, 8'h07);
    CLK_EN <= 1'b0;
    repeat (400) @(posedge REF_CLK);
    CLK_EN <= 1'b1;
    rd(ACS_OFS_CTL);
    `CHK("frozen", 1'b0, rdat[7])
    wdone();
    chkres(8'h07);
    $display("test registers done");
    tally_and_finish();
  end
endmodule // acs_adc_sequencer_tb_top
bind acs_adc_sequencer acs_adc_monitor u_mon (.REF_CLK, .ARST_N,
  .AWADDR, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY,
  .ARVALID, .ARREADY, .ARADDR, .RDATA, .RVALID, .RREADY, .E_TICK,
  .RC_TICK, .STOP_MODE, .WAIT_MODE, .MUX_SEL, .SRC_KIND, .SAMPLE_CLOSE,
  .CONV_POWER);
`default_nettype wire
